// ===== logic/kbm_pkg.sv
// Purpose: constants of the keyboard host mailbox
// Assumes: 250 MHz system clock
// Notes:   offsets, fields, reset values, timing
package kbm_pkg;
  // ----------------------------------------
  // host addresses (full byte address)
  // ----------------------------------------
  localparam logic [7:0] MAILBOX_DATA_PORT    = 8'h60;
  localparam logic [7:0] MAILBOX_CONTROL_PORT = 8'h64;
  localparam int         ADDR_BIT_TWO         = 2;
  // ----------------------------------------
  // status fields
  // ----------------------------------------
  localparam int         ST_OUTF     = 0;
  localparam int         ST_INF      = 1;
  localparam int         ST_CD       = 3;
  localparam logic [7:0] ST_USER_MSK = 8'hF4;
  localparam logic [7:0] ST_RESET    = 8'h00;
  // ----------------------------------------
  // port 2 bit positions and reset value
  // ----------------------------------------
  localparam int         P2_GATE_A20 = 1;
  localparam int         P2_MS_DAT   = 2;
  localparam int         P2_MS_CLK   = 3;
  localparam int         P2_KBD_IRQ  = 4;
  localparam int         P2_AUX_IRQ  = 5;
  localparam int         P2_KB_CLK   = 6;
  localparam int         P2_KB_DAT   = 7;
  // pins low, irq bits low, a20 low after reset
  localparam logic [7:0] P2_RESET    = 8'hCC;
  // ----------------------------------------
  // port 1 quasi pins: bits 7, 6, 2
  // ----------------------------------------
  localparam int         P1_QA       = 7;
  localparam int         P1_QB       = 6;
  localparam int         P1_QC       = 2;
  localparam logic [7:0] P1_RESET    = 8'hFF;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ       = 250;
  localparam int QUASI_HOLD_NS = 500;
  localparam int QUASI_HOLD_CYC = (QUASI_HOLD_NS * CLK_MHZ) / 1000;
  localparam int QCNT_W        = 8;
  localparam int FIFO_DEPTH    = 16;
  localparam int FIFO_WIDTH    = 8;
  // power states
  typedef enum logic [1:0] {PWR_RUN, PWR_HALT, PWR_STOP} kbm_pwr_e;
endpackage : kbm_pkg

// ===== logic/kbm_mailbox.sv
// Purpose: host mailbox, irq lines and port pins of the keyboard controller
// Assumes: all inputs but arst_n_in synchronous to clk_sys_in
// Notes:   cpu output bytes pass a 16 word FIFO before the output register

// ----------------------------------------
// generic FIFO, flip-flop storage
// ----------------------------------------
module kbm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  // fill side
  input  wire logic             push_valid_in,
  output logic                  push_ready_out,
  input  wire logic [WIDTH-1:0] push_data_in,
  // drain side
  output logic                  pop_valid_out,
  input  wire logic             pop_ready_in,
  output logic      [WIDTH-1:0] pop_data_out
);
  localparam int AW = $clog2(DEPTH);
  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  // handshake decode
  wire do_push = push_valid_in & push_ready_out;
  wire do_pop  = pop_valid_out & pop_ready_in;

  // honest full and empty from the count
  assign push_ready_out = (count != (AW+1)'(DEPTH));
  assign pop_valid_out  = (count != '0);
  assign pop_data_out   = mem[rd_ptr];

  // storage write, no reset needed on data
  always_ff @(posedge clk_sys_in) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_in;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (do_pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= (AW+1)'(count + do_push - do_pop);
    end
  end
endmodule : kbm_fifo

// ----------------------------------------
// top: mailbox, flags, pins, power modes
// ----------------------------------------
module kbm_mailbox (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       arst_n_in,
  // host I/O port
  input  wire logic       host_cs_in,
  input  wire logic       host_wr_in,
  input  wire logic       host_rd_in,
  input  wire logic [7:0] host_addr_in,
  input  wire logic [7:0] host_wdata_in,
  output logic      [7:0] host_rdata_out,
  // embedded cpu: mailbox
  input  wire logic       cpu_out_valid_in,
  output logic            cpu_out_ready_out,
  input  wire logic [7:0] cpu_out_data_in,
  input  wire logic       cpu_in_read_in,
  output logic      [7:0] cpu_input_mailbox_out,
  input  wire logic       cpu_status_we_in,
  input  wire logic [7:0] cpu_status_in,
  output logic      [7:0] cpu_status_out,
  // embedded cpu: ports and modes
  input  wire logic       cpu_port2_we_in,
  input  wire logic [7:0] cpu_port2_in,
  input  wire logic       cpu_port1_we_in,
  input  wire logic [7:0] cpu_port1_in,
  input  wire logic       en_flags_cmd_in,
  input  wire logic       open_drain_in,
  input  wire logic       ibf_int_en_in,
  input  wire logic       tmr_int_en_in,
  input  wire logic       timer_ovf_in,
  input  wire logic       halt_cmd_in,
  input  wire logic       stop_cmd_in,
  // embedded cpu: interrupts and clocks
  output logic            input_full_cpu_interrupt_out,
  output logic            timer_cpu_interrupt_out,
  output logic            resume_call_out,
  output logic            alu_clk_en_out,
  output logic            osc_en_out,
  // host interrupt lines and gate
  output logic            kbd_interrupt_out,
  output logic            aux_interrupt_out,
  output logic            gate_a20_out,
  // quasi pins a, b, c (bit 2 = a)
  output logic      [2:0] quasi_pin_out,
  output logic      [2:0] quasi_pin_oe_out,
  // keyboard and mouse open-drain pins
  input  wire logic       keyboard_clock_pin_in,
  input  wire logic       keyboard_data_pin_in,
  input  wire logic       mouse_clock_pin_in,
  input  wire logic       mouse_data_pin_in,
  output logic      [3:0] kbms_pin_out,
  output logic      [3:0] kbms_pin_oe_out,
  // pin readback towards the cpu
  output logic            test_input_zero_out,
  output logic            test_input_one_out,
  output logic            port1_bit_zero_out,
  output logic            port1_bit_one_out
);
  import kbm_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic       rst_meta;     // first stage
  logic       rst_n;        // released copy

  // two-stage release; assert is asynchronous
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] in_reg;       // input mailbox
  logic [7:0] out_reg;      // output register
  logic [7:0] status;       // host status
  logic [7:0] port2;        // cpu port 2
  logic [7:0] port1;        // cpu port 1
  logic       en_flags;     // sticky flag mode
  kbm_pwr_e   pwr;          // power mode
  kbm_pwr_e   next_pwr;     // power mode next
  logic [QCNT_W-1:0] qcnt [3]; // drive-high timers

  // ----------------------------------------
  // host decode
  // ----------------------------------------
  // full address selects data or command port; host_addr bit two sets the command flag
  wire sel_data = host_cs_in & (host_addr_in == MAILBOX_DATA_PORT);
  wire sel_ctl  = host_cs_in & (host_addr_in == MAILBOX_CONTROL_PORT);
  wire host_wr  = (sel_data | sel_ctl) & host_wr_in;
  wire data_rd  = sel_data & host_rd_in;
  wire ctl_rd   = sel_ctl & host_rd_in;
  wire host_address_bit_two = host_addr_in[ADDR_BIT_TWO];

  // ----------------------------------------
  // cpu output fifo
  // ----------------------------------------
  wire       drain_valid;
  wire [7:0] drain_data;
  // drain only into an empty output register, so
  // cpu bytes are never overwritten unread
  wire       drain_ready = ~status[ST_OUTF];
  wire       outf_load   = drain_valid & drain_ready;

  kbm_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .clk_sys_in     (clk_sys_in),
    .rst_n_in       (rst_n),
    .push_valid_in  (cpu_out_valid_in),
    .push_ready_out (cpu_out_ready_out),
    .push_data_in   (cpu_out_data_in),
    .pop_valid_out  (drain_valid),
    .pop_ready_in   (drain_ready),
    .pop_data_out   (drain_data)
  );

  // ----------------------------------------
  // status next value
  // ----------------------------------------
  logic [7:0] next_status;

  always_comb begin
    next_status = status;
    // cpu rewrites user bits only
    if (cpu_status_we_in) begin
      next_status = (status & ~ST_USER_MSK) | (cpu_status_in & ST_USER_MSK);
    end
    if (cpu_in_read_in) begin
      next_status[ST_INF] = 1'b0;
    end
    if (data_rd) begin
      next_status[ST_OUTF] = 1'b0;
    end
    if (outf_load) begin
      next_status[ST_OUTF] = 1'b1;
    end
    if (host_wr) begin
      next_status[ST_INF] = 1'b1;
      next_status[ST_CD]  = host_address_bit_two;
    end
  end

  // ----------------------------------------
  // mailbox registers
  // ----------------------------------------
  // status cleared on reset
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      status <= ST_RESET;
    end else begin
      status <= next_status;
    end
  end

  // data registers; both cleared on reset
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      in_reg  <= '0;
      out_reg <= '0;
    end else begin
      if (host_wr) begin
        in_reg <= host_wdata_in;
      end
      if (outf_load) begin
        out_reg <= drain_data;
      end
    end
  end

  // host read data, registered one cycle
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata_out <= '0;
    end else if (data_rd) begin
      host_rdata_out <= out_reg;
    end else if (ctl_rd) begin
      host_rdata_out <= status;
    end
  end

  assign cpu_status_out        = status;
  assign cpu_input_mailbox_out = in_reg;

  // ----------------------------------------
  // cpu ports and flag mode
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      port2    <= P2_RESET;
      port1    <= P1_RESET;
      en_flags <= 1'b0;
    end else begin
      if (cpu_port2_we_in) begin
        port2 <= cpu_port2_in;
      end
      if (cpu_port1_we_in) begin
        port1 <= cpu_port1_in;
      end
      // once set, only reset leaves flag mode
      if (en_flags_cmd_in) begin
        en_flags <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // host interrupt lines
  // ----------------------------------------
  // gated out-full and input-empty
  wire kbd_flag = port2[P2_KBD_IRQ] & status[ST_OUTF];
  wire aux_flag = port2[P2_AUX_IRQ] & ~status[ST_INF];

  assign kbd_interrupt_out = en_flags ? kbd_flag : port2[P2_KBD_IRQ];
  assign aux_interrupt_out = en_flags ? aux_flag : port2[P2_AUX_IRQ];
  assign gate_a20_out      = port2[P2_GATE_A20];

  // ----------------------------------------
  // cpu interrupts
  // ----------------------------------------
  // two sources only
  assign input_full_cpu_interrupt_out = status[ST_INF] & ibf_int_en_in;
  assign timer_cpu_interrupt_out      = timer_ovf_in & tmr_int_en_in;

  // ----------------------------------------
  // quasi-bidirectional pins
  // ----------------------------------------
  wire [2:0] qbits = {port1[P1_QA], port1[P1_QB], port1[P1_QC]};
  logic [2:0] qbits_q;      // last port value
  wire  [2:0] qrise = qbits & ~qbits_q; // drive high at once, before the timer loads

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      qbits_q <= {P1_RESET[P1_QA], P1_RESET[P1_QB], P1_RESET[P1_QC]}; // idle level, no false rise
      for (int i = 0; i < 3; i++) begin
        qcnt[i] <= '0;
      end
    end else begin
      qbits_q <= qbits;
      for (int i = 0; i < 3; i++) begin
        if (qrise[i]) begin
          qcnt[i] <= QCNT_W'(QUASI_HOLD_CYC - 1); // rise cycle already drove
        end else if (qcnt[i] != '0) begin
          qcnt[i] <= QCNT_W'(qcnt[i] - 1'b1);
        end
      end
    end
  end

  // drive low on zero, strong high while timer runs
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      quasi_pin_out[i] = qbits[i] & ~open_drain_in;
      if (open_drain_in) begin
        quasi_pin_oe_out[i] = ~qbits[i];
      end else begin
        quasi_pin_oe_out[i] = ~qbits[i] | qrise[i] | (qcnt[i] != '0);
      end
    end
  end

  // ----------------------------------------
  // keyboard and mouse pins
  // ----------------------------------------
  // inverted open drain
  // order: keyboard clock, keyboard data, mouse clock, mouse data
  assign kbms_pin_out    = '0;
  assign kbms_pin_oe_out = {port2[P2_KB_CLK], port2[P2_KB_DAT],
                            port2[P2_MS_CLK], port2[P2_MS_DAT]};
  assign test_input_zero_out = keyboard_clock_pin_in;
  assign port1_bit_zero_out  = keyboard_data_pin_in;
  assign test_input_one_out  = mouse_clock_pin_in;
  assign port1_bit_one_out   = mouse_data_pin_in;

  // ----------------------------------------
  // power modes
  // ----------------------------------------
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      PWR_RUN: begin
        if (stop_cmd_in) begin
          next_pwr = PWR_STOP;
        end else if (halt_cmd_in) begin
          next_pwr = PWR_HALT;
        end
      end
      PWR_HALT, PWR_STOP: begin
        if (host_wr) begin
          next_pwr = PWR_RUN;
        end
      end
      default: begin
        next_pwr = PWR_RUN;
      end
    endcase
  end

  // reset always returns to run mode
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      pwr             <= PWR_RUN;
      resume_call_out <= 1'b0;
    end else begin
      pwr             <= next_pwr;
      // wake with input-full interrupt enabled calls the routine
      resume_call_out <= (pwr != PWR_RUN) & host_wr & ibf_int_en_in;
    end
  end

  assign alu_clk_en_out = (pwr == PWR_RUN);
  assign osc_en_out     = (pwr != PWR_STOP);

endmodule : kbm_mailbox

// ===== tb/kbm_mailbox_asserts.sv
// Purpose: port checks of the keyboard host mailbox
// Assumes: internal reset ends two edges after release
// Notes:   port 1/2 and flag mode are shadowed from write pulses
module kbm_mailbox_asserts (
  // clock, reset, host port
  input wire logic       clk_sys_in, arst_n_in, host_cs_in, host_wr_in, host_rd_in,
  input wire logic [7:0] host_addr_in, host_wdata_in, host_rdata_out,
  // cpu side
  input wire logic       cpu_out_valid_in, cpu_out_ready_out, cpu_in_read_in,
  input wire logic [7:0] cpu_input_mailbox_out, cpu_status_out, cpu_port2_in, cpu_port1_in,
  input wire logic       cpu_port2_we_in, cpu_port1_we_in, en_flags_cmd_in, open_drain_in,
  input wire logic       halt_cmd_in, stop_cmd_in, alu_clk_en_out, osc_en_out,
  // host lines and pins
  input wire logic       kbd_interrupt_out, aux_interrupt_out, gate_a20_out,
  input wire logic [2:0] quasi_pin_out, quasi_pin_oe_out,
  input wire logic [3:0] kbms_pin_out, kbms_pin_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import kbm_pkg::*;
  // ----------------------------------------
  // shadows and decode
  // ----------------------------------------
  logic       sync_q, live; // two flops, like the design's reset copy
  logic [7:0] p2, p1;       // last port values
  logic       flg;          // sticky flag mode
  wire hw_dat = host_cs_in && host_wr_in && host_addr_in == MAILBOX_DATA_PORT;
  wire hw_cmd = host_cs_in && host_wr_in && host_addr_in == MAILBOX_CONTROL_PORT;
  wire hr_dat = host_cs_in && host_rd_in && host_addr_in == MAILBOX_DATA_PORT;
  wire hr_cmd = host_cs_in && host_rd_in && host_addr_in == MAILBOX_CONTROL_PORT;
  wire hw_any = hw_dat || hw_cmd;
  wire push   = cpu_out_valid_in && cpu_out_ready_out;
  // shadows ignore writes during the design's own reset edges
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {sync_q, live, flg} <= 3'h0;
      p2                  <= P2_RESET;
      p1                  <= P1_RESET;
    end else begin
      sync_q <= 1'b1;
      live   <= sync_q;
      if (live && cpu_port2_we_in) p2 <= cpu_port2_in;
      if (live && cpu_port1_we_in) p1 <= cpu_port1_in;
      if (live && en_flags_cmd_in) flg <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!live);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_push_idle; push && !cpu_status_out[ST_OUTF]; endsequence
  sequence s_outf_up; ##[1:3] cpu_status_out[ST_OUTF]; endsequence
  property p_dat_wr; hw_dat |=> cpu_status_out[ST_INF] && !cpu_status_out[ST_CD]
    && cpu_input_mailbox_out == $past(host_wdata_in); endproperty
  property p_cmd_wr; hw_cmd |=> cpu_status_out[ST_INF] && cpu_status_out[ST_CD]
    && cpu_input_mailbox_out == $past(host_wdata_in); endproperty
  property p_stat_rd; hr_cmd |=> host_rdata_out == $past(cpu_status_out); endproperty
  property p_outf_clr; hr_dat |=> !cpu_status_out[ST_OUTF]; endproperty
  property p_inf_clr; cpu_in_read_in && !hw_any |=> !cpu_status_out[ST_INF]; endproperty
  property p_outf_set; s_push_idle |-> s_outf_up; endproperty
  property p_kbd_irq;
    kbd_interrupt_out == (p2[P2_KBD_IRQ] && (!flg || cpu_status_out[ST_OUTF]));
  endproperty
  property p_aux_irq;
    aux_interrupt_out == (p2[P2_AUX_IRQ] && (!flg || !cpu_status_out[ST_INF]));
  endproperty
  property p_pins; gate_a20_out == p2[P2_GATE_A20] && kbms_pin_out == 4'h0
    && kbms_pin_oe_out == {p2[P2_KB_CLK], p2[P2_KB_DAT], p2[P2_MS_CLK], p2[P2_MS_DAT]}; endproperty
  property p_od; open_drain_in [*2] |-> quasi_pin_out == 3'h0
    && quasi_pin_oe_out == ~{p1[P1_QA], p1[P1_QB], p1[P1_QC]}; endproperty
  property p_sleep; (halt_cmd_in || stop_cmd_in) && !hw_any |=> !alu_clk_en_out; endproperty
  property p_stop; stop_cmd_in && !hw_any |=> !osc_en_out; endproperty
  property p_wake; hw_any && !halt_cmd_in && !stop_cmd_in |=> alu_clk_en_out && osc_en_out; endproperty
  a_dat_wr: assert property (p_dat_wr) else $error("data write flags wrong");
  a_cmd_wr: assert property (p_cmd_wr) else $error("command write flags wrong");
  a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");
  a_outf_clr: assert property (p_outf_clr) else $error("output full kept");
  a_inf_clr: assert property (p_inf_clr) else $error("input full kept");
  a_outf_set: assert property (p_outf_set) else $error("output full not set");
  a_kbd_irq: assert property (p_kbd_irq) else $error("keyboard irq wrong");
  a_aux_irq: assert property (p_aux_irq) else $error("aux irq wrong");
  a_pins: assert property (p_pins) else $error("gate or pin drive wrong");
  a_od: assert property (p_od) else $error("open drain drive wrong");
  a_sleep: assert property (p_sleep) else $error("alu clock still on");
  a_stop: assert property (p_stop) else $error("oscillator still on");
  a_wake: assert property (p_wake) else $error("host write did not wake");
endmodule : kbm_mailbox_asserts

bind kbm_mailbox kbm_mailbox_asserts i_chk (.*);

// ===== tb/kbm_host_model.sv
// Purpose: host processor issuing single-cycle I/O reads and writes
// Assumes: strobes sampled on the rising clock edge
// Notes:   released address and data turn over, never keep stale values
module kbm_host_model (
  // clock
  input  wire logic       clk_sys_in,
  // host I/O strobes
  output logic            host_cs_out,
  output logic            host_wr_out,
  output logic            host_rd_out,
  output logic      [7:0] host_addr_out,
  output logic      [7:0] host_wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {host_cs_out, host_wr_out, host_rd_out} = 3'h0;
    {host_addr_out, host_wdata_out} = 16'h0000;
  end
  // one transfer: held for exactly one taking edge
  task automatic cycle(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    #1;
    {host_cs_out, host_wr_out, host_rd_out} = {1'b1, w, !w};
    {host_addr_out, host_wdata_out} = {a, d};
    @(posedge clk_sys_in);
    #1;
    {host_cs_out, host_wr_out, host_rd_out} = 3'h0;
    {host_addr_out, host_wdata_out} = ~{a, d};
  endtask : cycle
endmodule : kbm_host_model

// ===== tb/kbm_mailbox_bench.sv
// Purpose: self-checking bench of the keyboard host mailbox
// Assumes: 250 MHz clock, inputs moved 1 ns after the rising edge
// Notes:   read data is checked by a watcher against queued notes
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module kbm_mailbox_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import kbm_pkg::*;
  // ----------------------------------------
  // design signals, all named as its ports
  // ----------------------------------------
  logic       clk_sys_in = 1'b0;
  logic       arst_n_in, host_cs_in, host_wr_in, host_rd_in, cpu_out_valid_in, cpu_out_ready_out;
  logic [7:0] host_addr_in, host_wdata_in, host_rdata_out, cpu_out_data_in, cpu_input_mailbox_out;
  logic       cpu_in_read_in, cpu_status_we_in, cpu_port2_we_in, cpu_port1_we_in, en_flags_cmd_in;
  logic [7:0] cpu_status_in, cpu_status_out, cpu_port2_in, cpu_port1_in;
  logic       open_drain_in, ibf_int_en_in, tmr_int_en_in, timer_ovf_in, halt_cmd_in, stop_cmd_in;
  logic       input_full_cpu_interrupt_out, timer_cpu_interrupt_out, resume_call_out;
  logic       alu_clk_en_out, osc_en_out, kbd_interrupt_out, aux_interrupt_out, gate_a20_out;
  logic [2:0] quasi_pin_out, quasi_pin_oe_out;
  logic       keyboard_clock_pin_in, keyboard_data_pin_in, mouse_clock_pin_in, mouse_data_pin_in;
  logic [3:0] kbms_pin_out, kbms_pin_oe_out;
  logic       test_input_zero_out, test_input_one_out, port1_bit_zero_out, port1_bit_one_out;
  // ----------------------------------------
  // bench state
  // ----------------------------------------
  int         err_total, n_compared;
  int         seed = 32'h7d36_32b1;
  logic [7:0] exp_q[$], fq[$];   // read notes, bytes in flight
  logic [7:0] r, exp_v;
  logic       rd_seen = 1'b0;
  logic       acc;
  always #2 clk_sys_in = ~clk_sys_in;
  // open-drain pins with pull-ups
  assign {keyboard_clock_pin_in, keyboard_data_pin_in, mouse_clock_pin_in, mouse_data_pin_in} =
    ~(kbms_pin_oe_out & ~kbms_pin_out);
  kbm_mailbox i_dut (.*);
  kbm_host_model i_host (
    .clk_sys_in     (clk_sys_in),
    .host_cs_out    (host_cs_in),
    .host_wr_out    (host_wr_in),
    .host_rd_out    (host_rd_in),
    .host_addr_out  (host_addr_in),
    .host_wdata_out (host_wdata_in)
  );
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask : pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.cycle(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.cycle(1'b0, a, 8'h00);
  endtask : rd
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  // watcher: read data is settled half a cycle after the taking edge
  always @(negedge clk_sys_in) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        exp_v = exp_q.pop_front();
        `CHK(host_rdata_out, exp_v)
      end
    end
    rd_seen = host_cs_in && host_rd_in;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {arst_n_in, cpu_out_valid_in, cpu_in_read_in, cpu_status_we_in, cpu_port2_we_in} = 5'h00;
    {cpu_port1_we_in, en_flags_cmd_in, open_drain_in, ibf_int_en_in, tmr_int_en_in} = 5'h00;
    {timer_ovf_in, halt_cmd_in, stop_cmd_in} = 3'h0;
    {cpu_out_data_in, cpu_status_in, cpu_port2_in, cpu_port1_in} = 32'h0000_0000;
    tick(6);
    arst_n_in = 1'b1;
    tick(3);
    rd(MAILBOX_CONTROL_PORT, ST_RESET);
    `CHK(kbd_interrupt_out, 1'b0)
    `CHK({quasi_pin_oe_out, quasi_pin_out}, 6'h07)
    // random port 2 values reach irq lines, gate and pins
    for (int i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      cpu_port2_in = r;
      pulse(cpu_port2_we_in);
      `CHK({kbd_interrupt_out, aux_interrupt_out}, {r[4], r[5]})
      `CHK(gate_a20_out, r[1])
      `CHK({kbms_pin_out, kbms_pin_oe_out}, {4'h0, r[6], r[7], r[3], r[2]})
      `CHK({test_input_zero_out, port1_bit_zero_out, test_input_one_out, port1_bit_one_out}, ~{r[6], r[7], r[3], r[2]})
    end
    cpu_status_in = 8'hFF;
    pulse(cpu_status_we_in);
    rd(MAILBOX_CONTROL_PORT, 8'hF4);
    cpu_status_in = 8'h00;
    pulse(cpu_status_we_in);
    wr(MAILBOX_DATA_PORT, 8'hA5);
    `CHK(cpu_input_mailbox_out, 8'hA5)
    rd(MAILBOX_CONTROL_PORT, 8'h02);
    wr(MAILBOX_CONTROL_PORT, 8'h3C);
    `CHK(cpu_input_mailbox_out, 8'h3C)
    rd(MAILBOX_CONTROL_PORT, 8'h0A);
    // host write and cpu read meet in one cycle
    fork
      wr(MAILBOX_DATA_PORT, 8'h11);
      begin
        tick();
        pulse(cpu_in_read_in);
      end
    join
    wr(8'h65, 8'h77);
    rd(MAILBOX_CONTROL_PORT, 8'h02);
    rd(8'h61, 8'h02);
    pulse(cpu_in_read_in);
    rd(MAILBOX_CONTROL_PORT, 8'h00);
    // power modes
    pulse(halt_cmd_in);
    `CHK(alu_clk_en_out, 1'b0)
    wr(MAILBOX_DATA_PORT, 8'h22);
    `CHK({alu_clk_en_out, resume_call_out}, 2'h2)
    ibf_int_en_in = 1'b1;
    pulse(stop_cmd_in);
    `CHK({osc_en_out, input_full_cpu_interrupt_out}, 2'h1)
    wr(MAILBOX_DATA_PORT, 8'h33);
    `CHK({osc_en_out, resume_call_out}, 2'h3)
    pulse(cpu_in_read_in);
    `CHK(input_full_cpu_interrupt_out, 1'b0)
    {timer_ovf_in, tmr_int_en_in} = 2'h3;
    #1 `CHK(timer_cpu_interrupt_out, 1'b1)
    tmr_int_en_in = 1'b0;
    #1 `CHK(timer_cpu_interrupt_out, 1'b0)
    tick(); // back onto the 1 ns input grid
    // fill the output path until refused, then drain slowly
    acc = 1'b1;
    for (int i = 0; i < 40 && acc; i++) begin
      cpu_out_data_in = 8'($random(seed));
      cpu_out_valid_in = 1'b1;
      #1 acc = cpu_out_ready_out;
      if (acc) fq.push_back(cpu_out_data_in);
      tick();
    end
    cpu_out_valid_in = 1'b0;
    `CHK(fq.size(), 17)
    while (fq.size() > 0) begin
      tick(3);
      rd(MAILBOX_DATA_PORT, fq.pop_front());
    end
    rd(MAILBOX_CONTROL_PORT, 8'h00);
    `CHK(cpu_out_ready_out, 1'b1)
    // flag mode
    pulse(en_flags_cmd_in);
    cpu_port2_in = 8'h30;
    pulse(cpu_port2_we_in);
    `CHK({kbd_interrupt_out, aux_interrupt_out}, 2'h1)
    cpu_out_data_in = 8'h5A;
    pulse(cpu_out_valid_in);
    tick(2);
    `CHK(kbd_interrupt_out, 1'b1)
    wr(MAILBOX_DATA_PORT, 8'h44);
    `CHK(aux_interrupt_out, 1'b0)
    rd(MAILBOX_DATA_PORT, 8'h5A);
    `CHK(kbd_interrupt_out, 1'b0)
    cpu_out_data_in = 8'hC3;
    pulse(cpu_out_valid_in);
    tick(2);
    cpu_port2_in = 8'h20;
    pulse(cpu_port2_we_in);
    `CHK(kbd_interrupt_out, 1'b0)
    pulse(cpu_in_read_in);
    `CHK(aux_interrupt_out, 1'b1)
    rd(MAILBOX_DATA_PORT, 8'hC3);
    // quasi pins, open drain then strong-high pulse
    open_drain_in = 1'b1;
    cpu_port1_in = 8'h00;
    pulse(cpu_port1_we_in);
    `CHK({quasi_pin_oe_out, quasi_pin_out}, 6'h38)
    cpu_port1_in = 8'hFF;
    pulse(cpu_port1_we_in);
    `CHK({quasi_pin_oe_out, quasi_pin_out}, 6'h00)
    open_drain_in = 1'b0;
    cpu_port1_in = 8'h00;
    pulse(cpu_port1_we_in);
    `CHK({quasi_pin_oe_out, quasi_pin_out}, 6'h38)
    cpu_port1_in = 8'h44;
    pulse(cpu_port1_we_in);
    `CHK({quasi_pin_oe_out, quasi_pin_out}, 6'h3B)
    tick(QUASI_HOLD_CYC - 2);
    `CHK({quasi_pin_oe_out, quasi_pin_out}, 6'h3B)
    tick(4);
    `CHK({quasi_pin_oe_out, quasi_pin_out}, 6'h23)
    tick(2);
    `CHK(exp_q.size(), 0)
    wrap_up();
  end
endmodule : kbm_mailbox_bench
